// [design/hdlcc_pkg.sv]
// hdlcc_pkg: constants and carriers for the hdlc controller pin-level block
// assumes a 25 MHz system clock plus a separate serial bit clock domain
package hdlcc_pkg;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 19;
  localparam logic [4:0] FIFO_LAST = 5'h12;
  localparam logic [4:0] FIFO_FULL_COUNT = 5'h13;
  localparam logic [7:0] REG_RESET = 8'h00;
  // register select codes
  localparam logic [3:0] REG_FIFO_STATUS = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h1;
  localparam logic [3:0] REG_CONTROL = 4'h2;
  localparam logic [3:0] REG_RX_ADDRESS = 4'h3;
  localparam logic [3:0] REG_CCHAN_TX = 4'h4;
  localparam logic [3:0] REG_TIMING = 4'h5;
  localparam logic [3:0] REG_INT_FLAG = 4'h6;
  localparam logic [3:0] REG_INT_ENABLE = 4'h7;
  localparam logic [3:0] REG_GEN_STATUS = 4'h8;
  localparam logic [3:0] REG_CCHAN_RX = 4'h9;
  // field positions
  localparam int CTL_TX_ENABLE = 0;
  localparam int CTL_RX_ENABLE = 1;
  localparam int TMG_INTERNAL = 0;
  localparam int TMG_DOUBLE_RATE = 1;
  localparam int INT_TX_EMPTY = 0;
  localparam int INT_RX_AVAIL = 1;
  localparam int INT_RX_OVERFLOW = 2;
  localparam int INT_WD_EXPIRED = 3;
  localparam int FST_RX_EMPTY = 0;
  localparam int FST_RX_FULL = 1;
  localparam int FST_TX_EMPTY = 2;
  localparam int FST_TX_FULL = 3;
  localparam int GST_INTERNAL = 0;
  localparam int GST_WD_EXPIRED = 1;
  localparam int GST_WD_ARMED = 2;
  // frame layout on the link, and the watchdog last tick
  localparam logic [4:0] SLOT_CCHAN = 5'h01;
  localparam logic [4:0] SLOT_DATA_LO = 5'h02;
  localparam logic [4:0] SLOT_DATA_HI = 5'h04;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] BITS_AFTER_FIRST = 3'h7;
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic [7:0] WD_LAST_TICK = 8'h01;

  typedef struct packed {
    logic cs_n;
    logic rw;
    logic e;
    logic [3:0] addr;
    logic [7:0] wdata;
  } hdlcc_bus_t;

  typedef struct packed {
    logic internal;
    logic double_rate;
    logic tx_en;
    logic rx_en;
    logic [7:0] cchan_tx;
  } hdlcc_cfg_t;
endpackage

// [design/hdlcc_top.sv]
// hdlcc_top: host register port, packet byte stores, watchdog and serial link
// assumes host pins and frame pulse are asynchronous to CLOCK; link pins are timed by SERIAL_BIT_CLOCK
`timescale 1ns/1ps

module hdlcc_fifo (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // fill side
  input wire logic push,
  input wire logic [7:0] push_data,
  // drain side
  input wire logic pop,
  output logic [7:0] head,
  output logic empty,
  output logic full,
  output logic [4:0] count
);
  import hdlcc_pkg::*;
  logic [7:0] mem [FIFO_DEPTH];
  logic [4:0] wr_ptr;
  logic [4:0] rd_ptr;
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  function automatic logic [4:0] next_ptr(input logic [4:0] p);
    next_ptr = (p == FIFO_LAST) ? 5'h00 : p + 5'h01;
  endfunction

  assign empty = (count == 5'h00);
  assign full = (count == FIFO_FULL_COUNT);
  assign head = mem[rd_ptr];

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      count <= 5'h00;
    end else begin
      if (do_push) wr_ptr <= next_ptr(wr_ptr);
      if (do_pop) rd_ptr <= next_ptr(rd_ptr);
      count <= count + {4'h0, do_push} - {4'h0, do_pop};
    end
  end
endmodule // hdlcc_fifo

// Operation
// [R1] External timing: transmit runs only while tx clock gate is low; internal ignores it.
// [R2] Gate high puts serial output in high impedance; gate low drives it. Internal timing ignores the gate and drives in slots 0-4.
// [R3] External timing: receive clocks only while rx clock gate is low; internal ignores it.
// [R4] Internal timing: output data in slots 0,2,3,4, control channel in slot 1.
// [R5] External timing: serial output changes on bit clock rising edge while gate low.
// [R6] Peer supplies internal-timing input with data in slots 0,2,3,4, control in 1.
// [R7] External timing: input sampled on bit clock falling edge while rx gate low.
// [R8] Watchdog output stays high normally and goes low when the timer expires.
// [R9] Watchdog output stays low while reset input is held low.
// [R10] Interrupt output pulled low only when a flag and its enable are both set.
// [R11] Four-bit register select decoded with chip select, direction and enable strobe.
// [R12] Bus accesses are ignored while chip select is high.
// [R13] Address, direction and data act only while the enable strobe is active.
// [R14] Separate 19-byte first-in first-out stores for transmit and receive bytes.
// [R15] Serial output supported at bit rates up to 2.5 Mbps.
// [R16] Internal timing: bit clock at bit rate or twice, chosen by rate-select bit.
// [R17] Direction high drives read data onto the bus; low accepts host data.
// [R18] Frame pulse marks frame start and advances the watchdog timer.
// [R19] Reset clears all registers, both byte stores and the watchdog timer.
// [R20] Software bit picks internal or external timing for both serial directions.
module hdlcc_top (
  // system clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // host register port
  input wire logic [3:0] REGISTER_SELECT,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_NOT_WRITE,
  input wire logic ENABLE_STROBE,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE_N,
  // interrupt request, open drain
  input wire logic IRQ_N_IN,
  output logic IRQ_N_OUT,
  output logic IRQ_OE_N,
  // watchdog
  input wire logic FRAME_START_PULSE,
  output logic WATCHDOG_EXPIRY_N,
  // serial link
  input wire logic SERIAL_BIT_CLOCK,
  input wire logic TX_CLOCK_GATE_N,
  input wire logic RX_CLOCK_GATE_N,
  input wire logic SERIAL_DATA_IN,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OUT_OE_N
);
  import hdlcc_pkg::*;

  // host port: whole bus through two flops, then cycle capture
  hdlcc_bus_t bus_raw, bus_s1, bus_s2;
  logic e_prev, cyc_rw, rst_seen, wd_expired, wd_armed;
  logic [3:0] cyc_addr;
  logic [7:0] cyc_wdata, control_reg, rx_address_reg, timing_reg, int_enable_reg, int_flag, wd_count, rd_data;
  logic [7:0] cchan_tx_reg, next_rd_data;
  logic fp_s1, fp_s2, fp_s3;

  assign bus_raw = '{cs_n: CHIP_SELECT_N, rw: READ_NOT_WRITE, e: ENABLE_STROBE,
                     addr: REGISTER_SELECT, wdata: DATA_IN};

  function automatic logic [15:0] decode(input logic [3:0] a);
    decode = 16'h0001 << a;
  endfunction

  wire bus_sel = !bus_s2.cs_n && bus_s2.e; // [R12] [R13]
  wire cycle_end = e_prev && !bus_s2.e;
  wire [15:0] wr_hit = (cycle_end && !cyc_rw) ? decode(cyc_addr) : 16'h0000; // [R11]
  wire [15:0] rd_hit = (cycle_end && cyc_rw) ? decode(cyc_addr) : 16'h0000; // [R11]
  wire wd_tick = fp_s2 && !fp_s3; // [R18]

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      bus_s1 <= '{cs_n: 1'b1, default: '0};
      bus_s2 <= '{cs_n: 1'b1, default: '0};
      {fp_s1, fp_s2, fp_s3} <= 3'h0;
    end else begin
      bus_s1 <= bus_raw;
      bus_s2 <= bus_s1;
      {fp_s1, fp_s2, fp_s3} <= {FRAME_START_PULSE, fp_s1, fp_s2};
    end
  end

  // a cycle only counts if chip select was low while the strobe was high
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      e_prev <= 1'b0;
      cyc_rw <= 1'b1;
      cyc_addr <= 4'h0;
      cyc_wdata <= REG_RESET;
    end else begin
      e_prev <= bus_sel;
      if (bus_sel) begin
        cyc_rw <= bus_s2.rw;
        cyc_addr <= bus_s2.addr;
        cyc_wdata <= bus_s2.wdata;
      end
    end
  end

  // byte stores and link handoff state
  logic tx_put, tx_take_s1, tx_take_s2, rx_put_s1, rx_put_s2, rx_take;
  logic [7:0] tx_hold, rx_hold, cchan_rx_s1, cchan_rx_s2;
  logic [7:0] tx_head, rx_head;
  logic tx_empty, tx_full, rx_empty, rx_full;
  logic [4:0] tx_count, rx_count;
  wire tx_slot_free = (tx_put == tx_take_s2);
  wire tx_pop = tx_slot_free && !tx_empty && control_reg[CTL_TX_ENABLE]; // [R14]
  wire rx_arrive = (rx_put_s2 != rx_take);

  hdlcc_fifo u_tx_store ( // [R14]
    .clock(CLOCK), .rstn(RSTN), .push(wr_hit[REG_DATA]), .push_data(cyc_wdata),
    .pop(tx_pop), .head(tx_head), .empty(tx_empty), .full(tx_full), .count(tx_count));
  hdlcc_fifo u_rx_store ( // [R14]
    .clock(CLOCK), .rstn(RSTN), .push(rx_arrive), .push_data(rx_hold),
    .pop(rd_hit[REG_DATA]), .head(rx_head), .empty(rx_empty), .full(rx_full), .count(rx_count));

  // tx_hold only changes while the link has acknowledged, so it is stable when sampled there
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      tx_put <= 1'b0;
      tx_hold <= REG_RESET;
      rx_take <= 1'b0;
    end else begin
      if (tx_pop) begin
        tx_hold <= tx_head;
        tx_put <= !tx_put;
      end
      if (rx_arrive) rx_take <= rx_put_s2;
    end
  end

  // software registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin // [R19]
      control_reg <= REG_RESET;
      rx_address_reg <= REG_RESET;
      cchan_tx_reg <= REG_RESET;
      timing_reg <= REG_RESET;
      int_enable_reg <= REG_RESET;
    end else begin
      if (wr_hit[REG_CONTROL]) control_reg <= cyc_wdata;
      if (wr_hit[REG_RX_ADDRESS]) rx_address_reg <= cyc_wdata;
      if (wr_hit[REG_CCHAN_TX]) cchan_tx_reg <= cyc_wdata;
      if (wr_hit[REG_TIMING]) timing_reg <= cyc_wdata; // [R20]
      if (wr_hit[REG_INT_ENABLE]) int_enable_reg <= cyc_wdata;
    end
  end

  // sticky flags clear on read of the flag register; a new event in that cycle wins
  wire [7:0] flag_set = {4'h0, wd_tick && wd_armed && wd_count == WD_LAST_TICK,
                         rx_arrive && rx_full, !rx_empty, tx_empty};
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) int_flag <= REG_RESET;
    else int_flag <= (int_flag & ~(rd_hit[REG_INT_FLAG] ? 8'hff : 8'h00)) | flag_set;
  end

  // watchdog: loaded by a write, counts frame pulses, expires at zero
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin // [R19]
      rst_seen <= 1'b0;
      wd_count <= REG_RESET;
      wd_armed <= 1'b0;
      wd_expired <= 1'b0;
    end else begin
      rst_seen <= 1'b1;
      if (wr_hit[REG_INT_FLAG]) begin
        wd_count <= cyc_wdata;
        wd_armed <= (cyc_wdata != 8'h00);
        wd_expired <= 1'b0;
      end else if (wd_tick && wd_armed) begin // [R18]
        wd_count <= wd_count - 8'h01;
        if (wd_count == WD_LAST_TICK) begin // [R8]
          wd_armed <= 1'b0;
          wd_expired <= 1'b1;
        end
      end
    end
  end
  assign WATCHDOG_EXPIRY_N = rst_seen && !wd_expired; // [R8] [R9]

  always_comb begin
    case (bus_s2.addr)
      REG_FIFO_STATUS: next_rd_data = {4'h0, tx_full, tx_empty, rx_full, rx_empty};
      REG_DATA: next_rd_data = rx_head;
      REG_CONTROL: next_rd_data = control_reg;
      REG_RX_ADDRESS: next_rd_data = rx_address_reg;
      REG_CCHAN_TX: next_rd_data = cchan_tx_reg;
      REG_TIMING: next_rd_data = timing_reg;
      REG_INT_FLAG: next_rd_data = int_flag;
      REG_INT_ENABLE: next_rd_data = int_enable_reg;
      REG_GEN_STATUS: next_rd_data = {5'h00, wd_armed, wd_expired, timing_reg[TMG_INTERNAL]};
      REG_CCHAN_RX: next_rd_data = cchan_rx_s2;
      default: next_rd_data = 8'h00;
    endcase
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) rd_data <= REG_RESET;
    else rd_data <= next_rd_data;
  end

  assign DATA_OUT = rd_data;
  assign DATA_OE_N = !(bus_sel && bus_s2.rw); // [R17]
  assign IRQ_N_OUT = 1'b0;
  assign IRQ_OE_N = !(|(int_flag & int_enable_reg)); // [R10]

  // link domain: reset released on the bit clock
  hdlcc_cfg_t cfg, cfg_s1, cfg_s2;
  logic lrst_s1, lrst_n, tx_put_s1, tx_put_s2, tx_take, rx_take_s1, rx_take_s2, rx_put;
  logic fp_l, half, lbuf_full, drive_slot, rx_smp, rx_gate_smp;
  logic [7:0] bit_cnt, lbuf, tx_shift, rx_shift, cchan_shift, cchan_rx;
  logic [2:0] tx_bits, rx_bits;

  assign cfg = '{internal: timing_reg[TMG_INTERNAL], double_rate: timing_reg[TMG_DOUBLE_RATE],
                 tx_en: control_reg[CTL_TX_ENABLE], rx_en: control_reg[CTL_RX_ENABLE],
                 cchan_tx: cchan_tx_reg};

  always_ff @(posedge SERIAL_BIT_CLOCK or negedge RSTN) begin
    if (!RSTN) {lrst_s1, lrst_n} <= 2'b00;
    else {lrst_s1, lrst_n} <= {1'b1, lrst_s1};
  end

  // cfg is software-static; a write mid-frame may land one bit late
  always_ff @(posedge SERIAL_BIT_CLOCK or negedge lrst_n) begin
    if (!lrst_n) begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
      {tx_put_s1, tx_put_s2, rx_take_s1, rx_take_s2} <= 4'h0;
    end else begin
      cfg_s1 <= cfg;
      cfg_s2 <= cfg_s1;
      {tx_put_s1, tx_put_s2, rx_take_s1, rx_take_s2} <= {tx_put, tx_put_s1, rx_take, rx_take_s1};
    end
  end

  wire internal = cfg_s2.internal; // [R20]
  wire bit_en = !(internal && cfg_s2.double_rate) || half; // [R16]
  wire [4:0] slot = bit_cnt[7:3];
  wire slot_data = (slot == 5'h00) || (slot >= SLOT_DATA_LO && slot <= SLOT_DATA_HI); // [R4] [R6]
  wire slot_cchan = (slot == SLOT_CCHAN); // [R4]
  wire tx_run = cfg_s2.tx_en && (internal ? bit_en && slot_data : !TX_CLOCK_GATE_N); // [R1] [R5]
  wire rx_run = cfg_s2.rx_en && (internal ? bit_en && slot_data : !rx_gate_smp); // [R3] [R7]
  wire rx_byte_done = rx_run && rx_bits == LAST_BIT;

  // frame counter; frame pulse is timed by the bit clock, so one flop suffices
  always_ff @(posedge SERIAL_BIT_CLOCK or negedge lrst_n) begin
    if (!lrst_n) begin
      fp_l <= 1'b0;
      half <= 1'b0;
      bit_cnt <= 8'h00;
      drive_slot <= 1'b0;
    end else begin
      fp_l <= FRAME_START_PULSE;
      if (fp_l && internal) begin // [R18]
        half <= 1'b0;
        bit_cnt <= 8'h00;
      end else begin
        half <= !half;
        if (bit_en) bit_cnt <= bit_cnt + 8'h01;
      end
      if (bit_en) drive_slot <= slot_data || slot_cchan;
    end
  end

  // transmit shifter, lsb first, idle ones when nothing is queued; up to 2.5 Mbps [R15]
  always_ff @(posedge SERIAL_BIT_CLOCK or negedge lrst_n) begin
    if (!lrst_n) begin
      tx_take <= 1'b0;
      lbuf_full <= 1'b0;
      lbuf <= REG_RESET;
      tx_shift <= REG_RESET;
      tx_bits <= 3'h0;
      SERIAL_DATA_OUT <= IDLE_LEVEL;
    end else begin
      if (tx_put_s2 != tx_take && !lbuf_full) begin
        lbuf <= tx_hold;
        lbuf_full <= 1'b1;
        tx_take <= tx_put_s2;
      end
      if (internal && cfg_s2.tx_en && bit_en && slot_cchan) begin // [R4]
        SERIAL_DATA_OUT <= cfg_s2.cchan_tx[~bit_cnt[2:0]];
      end else if (tx_run) begin // [R5]
        if (tx_bits != 3'h0) begin
          SERIAL_DATA_OUT <= tx_shift[0];
          tx_shift <= tx_shift >> 1;
          tx_bits <= tx_bits - 3'h1;
        end else if (lbuf_full) begin
          SERIAL_DATA_OUT <= lbuf[0];
          tx_shift <= lbuf >> 1;
          tx_bits <= BITS_AFTER_FIRST;
          lbuf_full <= 1'b0;
        end else begin
          SERIAL_DATA_OUT <= IDLE_LEVEL;
        end
      end
    end
  end
  assign SERIAL_DATA_OUT_OE_N = internal ? !(cfg_s2.tx_en && drive_slot) : TX_CLOCK_GATE_N; // [R2]

  // receive samples on the falling edge, consumed on the next rising edge
  always_ff @(negedge SERIAL_BIT_CLOCK or negedge lrst_n) begin
    if (!lrst_n) begin
      rx_smp <= IDLE_LEVEL;
      rx_gate_smp <= 1'b1;
    end else begin
      rx_smp <= SERIAL_DATA_IN; // [R7]
      rx_gate_smp <= RX_CLOCK_GATE_N; // [R3]
    end
  end

  // a byte takes 8 bit times, far longer than the handoff, so rx_hold cannot be overrun
  always_ff @(posedge SERIAL_BIT_CLOCK or negedge lrst_n) begin
    if (!lrst_n) begin
      rx_put <= 1'b0;
      rx_hold <= REG_RESET;
      rx_shift <= REG_RESET;
      rx_bits <= 3'h0;
      cchan_shift <= REG_RESET;
      cchan_rx <= REG_RESET;
    end else begin
      if (rx_run) begin
        rx_shift <= {rx_smp, rx_shift[7:1]};
        rx_bits <= rx_bits + 3'h1;
      end
      if (rx_byte_done) begin
        rx_hold <= {rx_smp, rx_shift[7:1]};
        rx_put <= !rx_put;
      end
      if (internal && bit_en && slot_cchan) begin // [R6]
        cchan_shift <= {cchan_shift[6:0], rx_smp};
        if (bit_cnt[2:0] == LAST_BIT) cchan_rx <= {cchan_shift[6:0], rx_smp};
      end
    end
  end

  // back to the system clock; control-channel byte changes at most once a frame
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      {tx_take_s1, tx_take_s2, rx_put_s1, rx_put_s2} <= 4'h0;
      cchan_rx_s1 <= REG_RESET;
      cchan_rx_s2 <= REG_RESET;
    end else begin
      {tx_take_s1, tx_take_s2, rx_put_s1, rx_put_s2} <= {tx_take, tx_take_s1, rx_put, rx_put_s1};
      cchan_rx_s1 <= cchan_rx;
      cchan_rx_s2 <= cchan_rx_s1;
    end
  end

  property p_wd_expire;
    @(posedge CLOCK) disable iff (!RSTN)
      (wd_tick && wd_armed && wd_count == WD_LAST_TICK && !wr_hit[REG_INT_FLAG]) |=> !WATCHDOG_EXPIRY_N;
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("watchdog did not expire"); // [R8]
  property p_wd_reset;
    @(posedge CLOCK) !RSTN |-> !WATCHDOG_EXPIRY_N;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("watchdog high in reset"); // [R9]
  property p_irq;
    @(posedge CLOCK) disable iff (!RSTN)
      (!rx_empty && int_enable_reg[INT_RX_AVAIL] && !wr_hit[REG_INT_ENABLE]) |=> !IRQ_OE_N;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag gave no interrupt"); // [R10]
  property p_cs_ignored;
    @(posedge CLOCK) disable iff (!RSTN) bus_s2.cs_n [*3] |-> $stable(timing_reg) && DATA_OE_N;
  endproperty
  a_cs_ignored: assert property (p_cs_ignored) else $error("access while deselected"); // [R12]
  property p_write;
    @(posedge CLOCK) disable iff (!RSTN) wr_hit[REG_TIMING] |=> timing_reg == $past(cyc_wdata);
  endproperty
  a_write: assert property (p_write) else $error("timing write lost"); // [R11] [R13]
  property p_read_drive;
    @(posedge CLOCK) disable iff (!RSTN) (bus_sel && bus_s2.rw) |-> !DATA_OE_N;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven"); // [R17]
  property p_depth;
    @(posedge CLOCK) disable iff (!RSTN) tx_count <= FIFO_FULL_COUNT && rx_count <= FIFO_FULL_COUNT;
  endproperty
  a_depth: assert property (p_depth) else $error("store over depth"); // [R14]
  property p_reset_clear;
    @(posedge CLOCK) $rose(RSTN) |-> tx_count == 5'h00 && rx_count == 5'h00 && int_flag == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not cleared"); // [R19]
  property p_gate_hiz;
    @(posedge SERIAL_BIT_CLOCK) disable iff (!lrst_n) (!internal && TX_CLOCK_GATE_N) |-> SERIAL_DATA_OUT_OE_N;
  endproperty
  a_gate_hiz: assert property (p_gate_hiz) else $error("output driven while gated"); // [R2]
  property p_tx_hold;
    @(posedge SERIAL_BIT_CLOCK) disable iff (!lrst_n)
      (!internal && TX_CLOCK_GATE_N) |=> SERIAL_DATA_OUT == $past(SERIAL_DATA_OUT);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("output moved while gated"); // [R1] [R5]
  property p_rx_hold;
    @(posedge SERIAL_BIT_CLOCK) disable iff (!lrst_n) (!internal && rx_gate_smp) |=> $stable(rx_bits);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive clocked while gated"); // [R3] [R7]
  property p_slot_hiz;
    @(posedge SERIAL_BIT_CLOCK) disable iff (!lrst_n)
      (internal && bit_en && slot > SLOT_DATA_HI) |=> SERIAL_DATA_OUT_OE_N;
  endproperty
  a_slot_hiz: assert property (p_slot_hiz) else $error("driven outside slots"); // [R4]
  property p_frame;
    @(posedge SERIAL_BIT_CLOCK) disable iff (!lrst_n) (fp_l && internal) |=> bit_cnt == 8'h00 && !half;
  endproperty
  a_frame: assert property (p_frame) else $error("frame start missed"); // [R18]
  property p_double_rate;
    @(posedge SERIAL_BIT_CLOCK) disable iff (!lrst_n)
      (internal && cfg_s2.double_rate && !fp_l && $stable(cfg_s2)) |=> half != $past(half);
  endproperty
  a_double_rate: assert property (p_double_rate) else $error("half rate not toggling"); // [R16] [R20]
endmodule // hdlcc_top

// [bench/hdlcc_peer.sv]
// hdlcc_peer: far-end link model in external timing, drives both gates and serial input
// assumes a free-running bit clock and a controller set to external timing
`timescale 1ns/1ps
module hdlcc_peer (
  // link clock
  input wire logic BIT_CLOCK,
  // controller output
  input wire logic SDO,
  input wire logic SDO_OE_N,
  // gates and controller input
  output logic TXG_N,
  output logic RXG_N,
  output logic SDI
);
  logic got[$];
  initial begin
    TXG_N = 1'b1;
    RXG_N = 1'b1;
    SDI = 1'b0;
  end
  // half a bit after the launching rising edge
  always @(negedge BIT_CLOCK) begin
    if (!SDO_OE_N) begin
      got.push_back(SDO);
    end
  end
  task automatic tx_run(input int n);
    @(posedge BIT_CLOCK);
    TXG_N <= 1'b0;
    repeat (n) @(posedge BIT_CLOCK);
    TXG_N <= 1'b1;
  endtask
  // lsb first; line flips while gated so a stale level never passes for data
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge BIT_CLOCK);
      RXG_N <= 1'b0;
      SDI <= b[i];
    end
    @(posedge BIT_CLOCK);
    RXG_N <= 1'b1;
    SDI <= ~b[7];
  endtask
endmodule // hdlcc_peer

// [bench/hdlcc_top_tb.sv]
// hdlcc_top_tb: self-checking bench with a queue model of registers and byte stores
// assumes hdlcc_top in external timing and the hdlcc_peer link model
`timescale 1ns/1ps
module hdlcc_top_tb;
  import hdlcc_pkg::*;
  logic clk, rstn, sbc, cs_n, rw, en, fp, doe_n, irq_out, irq_oe_n, wd_n, sdo, sdo_oe_n, txg_n, rxg_n, sdi;
  logic [3:0] a_sel;
  logic [7:0] din, dout, r, v, b;
  int err_total, samples_checked, cyc, m[16];
  logic [7:0] txq[$], rxq[$];
  wire irq_n = irq_oe_n ? 1'b1 : irq_out;
  hdlcc_top dut (.CLOCK(clk), .RSTN(rstn), .REGISTER_SELECT(a_sel), .CHIP_SELECT_N(cs_n), .READ_NOT_WRITE(rw),
    .ENABLE_STROBE(en), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(doe_n), .IRQ_N_IN(irq_n), .IRQ_N_OUT(irq_out),
    .IRQ_OE_N(irq_oe_n), .FRAME_START_PULSE(fp), .WATCHDOG_EXPIRY_N(wd_n), .SERIAL_BIT_CLOCK(sbc),
    .TX_CLOCK_GATE_N(txg_n), .RX_CLOCK_GATE_N(rxg_n), .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo),
    .SERIAL_DATA_OUT_OE_N(sdo_oe_n));
  hdlcc_peer peer (.BIT_CLOCK(sbc), .SDO(sdo), .SDO_OE_N(sdo_oe_n), .TXG_N(txg_n), .RXG_N(rxg_n), .SDI(sdi));
  always #20 clk = ~clk;
  initial begin
    sbc = 1'b0;
    #3;
    forever #7.5 sbc = ~sbc;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one host cycle; strobe held six cycles so the read data has settled
  task automatic acc(input logic c, input logic e, input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    cs_n = c;
    en = e;
    rw = ~w;
    a_sel = a;
    din = d;
    repeat (6) @(negedge clk);
    v = dout;
    chk({7'h0, doe_n}, {7'h0, c | ~e | w});
    en = 1'b0;
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
    if (!c && e && w) begin
      if (a == REG_DATA) begin
        if (txq.size() < FIFO_DEPTH) txq.push_back(d);
      end else begin
        m[a] = d;
      end
    end
  endtask
  function automatic logic [7:0] fstat();
    return {4'h0, txq.size() == FIFO_DEPTH, txq.size() == 0, rxq.size() == FIFO_DEPTH, rxq.size() == 0};
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    cs_n = 1'b1;
    rw = 1'b1;
    en = 1'b0;
    a_sel = 4'h0;
    din = 8'h00;
    fp = 1'b0;
    r = 8'h3f;
    foreach (m[i]) m[i] = 0;
    repeat (2) @(negedge clk);
    chk({7'h0, wd_n}, 8'h00);
    chk({7'h0, sdo_oe_n}, 8'h01);
    @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h0, wd_n}, 8'h01);
    r = lfsr(r);
    acc(1'b0, 1'b1, 1'b1, REG_RX_ADDRESS, r);
    r = lfsr(r);
    acc(1'b0, 1'b1, 1'b1, REG_CCHAN_TX, r);
    acc(1'b1, 1'b1, 1'b1, REG_RX_ADDRESS, ~r);
    acc(1'b0, 1'b0, 1'b1, REG_CCHAN_TX, ~r);
    for (int a = 3; a < 16; a++) begin
      if (a < 5 || a > 9) begin
        acc(1'b0, 1'b1, 1'b0, a[3:0], 8'h00);
        chk(v, m[a][7:0]);
      end
    end
    acc(1'b0, 1'b1, 1'b1, REG_INT_ENABLE, 8'h01);
    chk({7'h0, irq_oe_n}, 8'h00);
    acc(1'b0, 1'b1, 1'b1, REG_INT_ENABLE, 8'h00);
    chk({7'h0, irq_oe_n}, 8'h01);
    acc(1'b0, 1'b1, 1'b1, REG_INT_FLAG, 8'h03);
    for (int i = 1; i <= 3; i++) begin
      fp = 1'b1;
      repeat (4) @(negedge clk);
      fp = 1'b0;
      repeat (4) @(negedge clk);
      chk({7'h0, wd_n}, {7'h0, i < 3});
    end
    acc(1'b0, 1'b1, 1'b1, REG_INT_FLAG, 8'h00);
    chk({7'h0, wd_n}, 8'h01);
    acc(1'b0, 1'b1, 1'b1, REG_TIMING, 8'h03);
    // internal double-rate frame start; the disarmed watchdog must ignore it
    fp = 1'b1;
    repeat (4) @(negedge clk);
    fp = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h0, wd_n}, 8'h01);
    acc(1'b0, 1'b1, 1'b0, REG_GEN_STATUS, 8'h00);
    chk(v, {7'h0, m[5][0]});
    acc(1'b0, 1'b1, 1'b1, REG_TIMING, 8'h00);
    // even bytes: a zero start bit resyncs past idle ones between bytes
    for (int i = 0; i < 20; i++) begin
      r = lfsr(r);
      acc(1'b0, 1'b1, 1'b1, REG_DATA, r & 8'hfe);
    end
    acc(1'b0, 1'b1, 1'b0, REG_FIFO_STATUS, 8'h00);
    chk(v, fstat());
    acc(1'b0, 1'b1, 1'b1, REG_CONTROL, 8'h01);
    chk({7'h0, sdo_oe_n}, 8'h01);
    fork
      peer.tx_run(600);
      begin
        repeat (40) @(negedge clk);
        chk({7'h0, sdo_oe_n}, 8'h00);
      end
    join
    while (txq.size() > 0) begin
      while (peer.got.size() > 0 && peer.got[0] === 1'b1) peer.got.pop_front();
      for (int k = 0; k < 8; k++) b[k] = peer.got.pop_front();
      chk(b, txq.pop_front());
    end
    acc(1'b0, 1'b1, 1'b1, REG_CONTROL, 8'h02);
    for (int i = 0; i < 5; i++) begin
      r = lfsr(r);
      rxq.push_back(r);
      peer.send(r);
    end
    repeat (20) @(negedge clk);
    acc(1'b0, 1'b1, 1'b1, REG_INT_ENABLE, 8'h02);
    chk({7'h0, irq_n}, 8'h00);
    acc(1'b0, 1'b1, 1'b0, REG_FIFO_STATUS, 8'h00);
    chk(v, fstat());
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 1'b1, 1'b0, REG_DATA, 8'h00);
      chk(v, rxq.pop_front());
    end
    end_of_test();
  end
endmodule // hdlcc_top_tb
